// ### hw/csc_defines.vh
`ifndef CSC_DEFINES_VH
`define CSC_DEFINES_VH

// ----------------------------------------
// register map (word index, byte address is four times it)
// ----------------------------------------
`define CSC_IDX_CLOCK_CTRL 7'h6a
`define CSC_IDX_STANDBY 7'h6c
`define CSC_RST_CLOCK_CTRL 16'h0000
`define CSC_RST_STANDBY 16'h0000
`define CSC_MASK_CLOCK_CTRL 16'h00f3
`define CSC_MASK_STANDBY 16'h019f

// ----------------------------------------
// field positions
// ----------------------------------------
`define CSC_TRANSMIT_DATA_CLOCK_DIV_HI 7
`define CSC_TRANSMIT_DATA_CLOCK_DIV_LO 6
`define CSC_MCLK_DIV_HI 5
`define CSC_MCLK_DIV_LO 4
`define CSC_SRC_HI 1
`define CSC_SRC_LO 0
`define CSC_KEEP_CLOCK 8
`define CSC_KEEP_PULLUP 7
`define CSC_KEEP_SW1 4
`define CSC_KEEP_SW0 3
`define CSC_KEEP_BIAS 2
`define CSC_KEEP_EXC 1
`define CSC_KEEP_REF 0

// ----------------------------------------
// source codes
// ----------------------------------------
`define CSC_SRC_INT 2'b00
`define CSC_SRC_INT_OUT 2'b01
`define CSC_SRC_EXT 2'b10

`endif

// ### hw/csc_divider.v
`include "csc_defines.vh"

// ----------------------------------------
// power-of-two divider, enable pulse per period
// ----------------------------------------
module csc_divider (
    input wire aclk,
    input wire aresetn,
    input wire restart,
    input wire tick_in,
    input wire [1:0] log2_div,
    output reg tick_out,
    output reg clk_out
);
    reg [2:0] cnt_q;
    wire [2:0] top;
    assign top = (3'h1 << log2_div) - 3'h1;

    always @(posedge aclk) begin
        if (!aresetn || restart) begin
            cnt_q <= 3'h0;
            tick_out <= 1'b0;
            clk_out <= 1'b0;
        end else begin
            tick_out <= 1'b0;
            if (tick_in) begin
                if (cnt_q >= top) begin
                    cnt_q <= 3'h0;
                    tick_out <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 3'h1;
                end
                // square wave high in first half of period; divide by 1 toggles per tick
                clk_out <= (log2_div == 2'd0) ? ~clk_out : (cnt_q < (top >> 1) + 3'h1);
            end
        end
    end
endmodule // csc_divider

// ### hw/csc_sync2.v
// ----------------------------------------
// two-flop synchroniser
// ----------------------------------------
module csc_sync2 (
    input wire aclk,
    input wire aresetn,
    input wire d,
    output reg q
);
    reg meta_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // csc_sync2

// ### hw/csc_clock_standby.v
`include "csc_defines.vh"

module csc_clock_standby (
    input wire aclk,
    input wire aresetn,
    // axi4-lite slave
    input wire [8:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [8:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // clock sources
    input wire ext_clk_pin,
    input wire int_osc_clk,
    output reg osc_power_up,
    output reg clk_pin_out,
    output reg clk_pin_oe,
    // derived timing
    output wire main_clock_tick,
    output wire transmit_data_clock,
    output wire transmit_data_clock_tick,
    output reg converter_reset,
    // function enables from their own controls
    input wire standby,
    input wire main_clock_en,
    input wire pullup_en,
    input wire low_side_switch_1_en,
    input wire low_side_switch_0_en,
    input wire bias_en,
    input wire excitation_en,
    input wire reference_en,
    // effective function power
    output reg main_clock_on,
    output reg pullup_on,
    output reg low_side_switch_1,
    output reg low_side_switch_0,
    output reg bias_voltage_output,
    output reg excitation_on,
    output reg reference_on
);
    // ----------------------------------------
    // register state
    // ----------------------------------------
    reg [15:0] clock_ctrl_q;
    reg [15:0] standby_q;
    reg [8:0] aw_q;
    reg aw_have_q;
    reg [15:0] w_q;
    reg [1:0] ws_q;
    reg w_have_q;

    wire [1:0] data_clock_divider;
    wire [1:0] main_clock_divider;
    wire [1:0] clock_source_select;
    assign data_clock_divider = clock_ctrl_q[`CSC_TRANSMIT_DATA_CLOCK_DIV_HI:`CSC_TRANSMIT_DATA_CLOCK_DIV_LO];
    assign main_clock_divider = clock_ctrl_q[`CSC_MCLK_DIV_HI:`CSC_MCLK_DIV_LO];
    assign clock_source_select = clock_ctrl_q[`CSC_SRC_HI:`CSC_SRC_LO];

    // ----------------------------------------
    // axi4-lite write path
    // ----------------------------------------
    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready = !w_have_q && !s_axi_bvalid;

    wire [8:0] wr_addr;
    wire [15:0] wr_half;
    wire [1:0] wr_strb;
    wire wr_go;
    assign wr_addr = aw_have_q ? aw_q : s_axi_awaddr;
    assign wr_half = w_have_q ? w_q : s_axi_wdata[15:0];
    assign wr_strb = w_have_q ? ws_q : s_axi_wstrb[1:0];
    assign wr_go = (aw_have_q || (s_axi_awvalid && s_axi_awready)) &&
                   (w_have_q || (s_axi_wvalid && s_axi_wready));

    wire wr_clk_reg;
    wire wr_stb_reg;
    wire [15:0] wr_mask;
    // one register per word; its low and high byte on the two low byte lanes
    assign wr_clk_reg = wr_addr[8:2] == `CSC_IDX_CLOCK_CTRL;
    assign wr_stb_reg = wr_addr[8:2] == `CSC_IDX_STANDBY;
    assign wr_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

    always @(posedge aclk) begin
        if (!aresetn) begin
            clock_ctrl_q <= `CSC_RST_CLOCK_CTRL;
            standby_q <= `CSC_RST_STANDBY;
            aw_q <= 9'h000;
            aw_have_q <= 1'b0;
            w_q <= 16'h0000;
            ws_q <= 2'b00;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            converter_reset <= 1'b0;
        end else begin
            converter_reset <= 1'b0;
            if (s_axi_awvalid && s_axi_awready && !wr_go) begin
                aw_q <= s_axi_awaddr;
                aw_have_q <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready && !wr_go) begin
                w_q <= s_axi_wdata[15:0];
                ws_q <= s_axi_wstrb[1:0];
                w_have_q <= 1'b1;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_clk_reg || wr_stb_reg) ? 2'b00 : 2'b10;
                if (wr_clk_reg) begin
                    clock_ctrl_q <= ((clock_ctrl_q & ~wr_mask) | (wr_half & wr_mask))
                                    & `CSC_MASK_CLOCK_CTRL;
                    converter_reset <= 1'b1;
                end
                if (wr_stb_reg) begin
                    standby_q <= ((standby_q & ~wr_mask) | (wr_half & wr_mask))
                                 & `CSC_MASK_STANDBY;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // axi4-lite read path
    // ----------------------------------------
    assign s_axi_arready = !s_axi_rvalid;
    reg [15:0] rd_half;
    reg rd_ok;
    always @* begin
        rd_ok = 1'b1;
        rd_half = 16'h0000;
        if (s_axi_araddr[8:2] == `CSC_IDX_CLOCK_CTRL) begin
            rd_half = clock_ctrl_q;
        end else if (s_axi_araddr[8:2] == `CSC_IDX_STANDBY) begin
            rd_half = standby_q;
        end else begin
            rd_ok = 1'b0;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {16'h0000, rd_half};
            s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // clock source select
    // ----------------------------------------
    wire ext_s;
    wire osc_s;
    csc_sync2 u_sync_ext (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(ext_clk_pin),
        .q(ext_s)
    );
    csc_sync2 u_sync_osc (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(int_osc_clk),
        .q(osc_s)
    );

    reg src_q;
    reg src_prev_q;
    always @(posedge aclk) begin
        if (!aresetn) begin
            osc_power_up <= 1'b1;
            clk_pin_out <= 1'b0;
            clk_pin_oe <= 1'b0;
            src_q <= 1'b0;
            src_prev_q <= 1'b0;
        end else begin
            osc_power_up <= (clock_source_select == `CSC_SRC_INT) ||
                            (clock_source_select == `CSC_SRC_INT_OUT);
            clk_pin_oe <= clock_source_select == `CSC_SRC_INT_OUT;
            clk_pin_out <= osc_s;
            case (clock_source_select)
                `CSC_SRC_INT, `CSC_SRC_INT_OUT: src_q <= osc_s;
                `CSC_SRC_EXT: src_q <= ext_s;
                default: src_q <= 1'b0;
            endcase
            src_prev_q <= src_q;
        end
    end

    wire src_edge;
    assign src_edge = src_q && !src_prev_q;

    // ----------------------------------------
    // main and data clock dividers
    // ----------------------------------------
    wire main_clock_square;
    wire data_clock_square;
    wire [1:0] main_log2;
    assign main_log2 = (main_clock_divider == 2'b00) ? 2'd1 : main_clock_divider;

    csc_divider u_main_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .restart(converter_reset),
        .tick_in(src_edge),
        .log2_div(main_log2),
        .tick_out(main_clock_tick),
        .clk_out(main_clock_square)
    );

    // data clock follows the selected main clock only
    csc_divider u_data_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .restart(converter_reset),
        .tick_in(main_clock_tick),
        .log2_div(data_clock_divider),
        .tick_out(transmit_data_clock_tick),
        .clk_out(data_clock_square)
    );

    // divide by 1 passes the main clock square wave itself
    reg data_clock_q;
    always @(posedge aclk) begin
        if (!aresetn) begin
            data_clock_q <= 1'b0;
        end else begin
            data_clock_q <= (data_clock_divider == 2'b00) ? main_clock_square : data_clock_square;
        end
    end
    assign transmit_data_clock = data_clock_q;

    // ----------------------------------------
    // standby retention gating
    // ----------------------------------------
    wire [6:0] fn_en;
    wire [6:0] fn_keep;
    wire [6:0] fn_on_d;
    assign fn_en = {main_clock_en, pullup_en, low_side_switch_1_en, low_side_switch_0_en, bias_en, excitation_en,
                    reference_en};
    assign fn_keep = {standby_q[`CSC_KEEP_CLOCK], standby_q[`CSC_KEEP_PULLUP], standby_q[`CSC_KEEP_SW1],
                      standby_q[`CSC_KEEP_SW0], standby_q[`CSC_KEEP_BIAS], standby_q[`CSC_KEEP_EXC],
                      standby_q[`CSC_KEEP_REF]};

    genvar gi;
    generate
        for (gi = 0; gi < 7; gi = gi + 1) begin : g_keep
            // own enable always needed; retention only matters in standby
            assign fn_on_d[gi] = fn_en[gi] && (!standby || fn_keep[gi]);
        end
    endgenerate

    always @(posedge aclk) begin
        if (!aresetn) begin
            main_clock_on <= 1'b0;
            pullup_on <= 1'b0;
            low_side_switch_1 <= 1'b0;
            low_side_switch_0 <= 1'b0;
            bias_voltage_output <= 1'b0;
            excitation_on <= 1'b0;
            reference_on <= 1'b0;
        end else begin
            main_clock_on <= fn_on_d[6];
            pullup_on <= fn_on_d[5];
            low_side_switch_1 <= fn_on_d[4];
            low_side_switch_0 <= fn_on_d[3];
            bias_voltage_output <= fn_on_d[2];
            excitation_on <= fn_on_d[1];
            reference_on <= fn_on_d[0];
        end
    end
endmodule // csc_clock_standby

// ### testbench/csc_asserts.sv
module csc_asserts (
    input logic aclk,
    input logic aresetn,
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic s_axi_bvalid,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic [31:0] s_axi_rdata,
    input logic osc_power_up,
    input logic clk_pin_oe,
    input logic converter_reset,
    input logic reference_en,
    input logic reference_on
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ----------------------------------------
    // bus and control relations
    // ----------------------------------------
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
        else $error("write not answered");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while busy");
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while busy");
    a_reset_pulse: assert property (converter_reset |-> $rose(s_axi_bvalid) ##1 !converter_reset)
        else $error("converter reset not a write pulse");
    a_oe_needs_osc: assert property (clk_pin_oe |-> osc_power_up)
        else $error("clock pin driven without oscillator");
    a_gate_off: assert property (!reference_en |=> !reference_on)
        else $error("reference on while disabled");
endmodule // csc_asserts

bind csc_clock_standby csc_asserts u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .osc_power_up, .clk_pin_oe, .converter_reset, .reference_en, .reference_on);

// ### testbench/csc_clock_standby_tb.sv
module csc_clock_standby_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, ext_clk_pin, int_osc_clk, osc_power_up;
    logic [8:0] s_axi_awaddr, s_axi_araddr;
    localparam logic [8:0] clk_addr = 9'h06a << 2;
    localparam logic [8:0] stb_addr = 9'h06c << 2;
    localparam logic [8:0] bad_addr = 9'h070 << 2;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic clk_pin_out, clk_pin_oe, main_clock_tick, transmit_data_clock, transmit_data_clock_tick;
    logic converter_reset, standby, main_clock_en, pullup_en, low_side_switch_1_en, low_side_switch_0_en;
    logic bias_en, excitation_en, reference_en, main_clock_on, pullup_on, low_side_switch_1, low_side_switch_0;
    logic bias_voltage_output, excitation_on, reference_on;
    int fail_count, n_tests, resets_q, osc_q, p;
    wire [6:0] outs = {main_clock_on, pullup_on, low_side_switch_1, low_side_switch_0, bias_voltage_output,
        excitation_on, reference_on};

    csc_clock_standby uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_clk_pin,
        .int_osc_clk, .osc_power_up, .clk_pin_out, .clk_pin_oe, .main_clock_tick, .transmit_data_clock,
        .transmit_data_clock_tick, .converter_reset, .standby, .main_clock_en, .pullup_en, .low_side_switch_1_en,
        .low_side_switch_0_en, .bias_en, .excitation_en, .reference_en, .main_clock_on, .pullup_on,
        .low_side_switch_1, .low_side_switch_0, .bias_voltage_output, .excitation_on, .reference_on);

    initial begin
        aclk = 0;
        forever #5 aclk = ~aclk;
    end

    // ----------------------------------------
    // source clocks: oscillator period 4, pin period 6
    // ----------------------------------------
    always @(posedge aclk) begin
        osc_q <= osc_q + 1;
        int_osc_clk <= osc_q[1];
        ext_clk_pin <= (osc_q % 6) < 3;
        if (converter_reset === 1'b1) begin
            resets_q <= resets_q + 1;
        end
    end

    task complete_run;
        if (fail_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task chk(input [31:0] got, input [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask

    task timeout;
        chk(32'h0000_0000, 32'h0000_0001);
        complete_run;
    endtask

    task axi_write(input [8:0] a, input [31:0] d, input [3:0] s);
        bit aw, w, b;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        for (int i = 0; i < 50; i++) begin
            @(negedge aclk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 0;
            if (w) s_axi_wvalid <= 0;
            if (b) begin
                s_axi_bready <= 0;
                return;
            end
        end
        timeout;
    endtask

    task axi_read(input [8:0] a);
        bit ar, r;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        for (int i = 0; i < 50; i++) begin
            @(negedge aclk);
            ar = s_axi_arvalid && s_axi_arready;
            r = s_axi_rvalid;
            rd = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 0;
            if (r) begin
                s_axi_rready <= 0;
                return;
            end
        end
        timeout;
    endtask

    // interval between the 2nd and 3rd tick after a write
    // sel 0 main tick, 1 data tick, 2 data clock rising edge
    task period(input int sel);
        int seen, c;
        logic prev, hit;
        seen = 0;
        prev = transmit_data_clock;
        for (int i = 0; i < 3000; i++) begin
            @(negedge aclk);
            case (sel)
                0: hit = main_clock_tick === 1'b1;
                1: hit = transmit_data_clock_tick === 1'b1;
                default: hit = transmit_data_clock === 1'b1 && prev === 1'b0;
            endcase
            prev = transmit_data_clock;
            if (hit) begin
                seen++;
                if (seen == 3) begin
                    p = i - c;
                    return;
                end
                c = i;
            end
        end
        timeout;
    endtask

    task t_reset_vals;
        chk(osc_power_up, 1);
        axi_read(clk_addr);
        chk(rd, 0);
        axi_read(stb_addr);
        chk(rd, 0);
    endtask

    task t_regs;
        int n;
        n = resets_q;
        axi_write(clk_addr, 32'hffff_ffff, 4'b1111);
        chk(resp, 2'b00);
        @(negedge aclk);
        chk(resets_q, n + 1);
        axi_read(clk_addr);
        chk(rd, 32'h0000_00f3);
        axi_write(stb_addr, 32'hffff_ffff, 4'b0011);
        axi_read(stb_addr);
        chk(rd, 32'h0000_019f);
        axi_write(stb_addr, 32'h0000_0000, 4'b0010);
        axi_read(stb_addr);
        chk(rd, 32'h0000_009f);
        chk(resets_q, n + 1);
        axi_write(bad_addr, 32'h0000_ffff, 4'b1111);
        chk(resp, 2'b10);
        axi_read(bad_addr);
        chk(resp, 2'b10);
    endtask

    task t_sources;
        int ticks, rises;
        logic prev;
        for (int s = 0; s < 4; s++) begin
            axi_write(clk_addr, s, 4'b0011);
            repeat (2) @(negedge aclk);
            chk(osc_power_up, s < 2);
            chk(clk_pin_oe, s == 1);
            ticks = 0;
            rises = 0;
            prev = clk_pin_out;
            repeat (48) begin
                @(negedge aclk);
                ticks += main_clock_tick;
                rises += clk_pin_out && !prev;
                prev = clk_pin_out;
            end
            chk(ticks != 0, s != 3);
            chk(rises, 12);
        end
    endtask

    task t_dividers;
        int md[4] = '{2, 2, 4, 8};
        for (int k = 0; k < 4; k++) begin
            axi_write(clk_addr, k * 80, 4'b0011);
            period(0);
            chk(p, 4 * md[k]);
            period(1);
            chk(p, 4 * md[k] * (1 << k));
            period(2);
            chk(p, 4 * md[k] * (1 << k));
        end
        axi_write(clk_addr, 32'h0000_0002, 4'b0011);
        period(0);
        chk(p, 12);
    endtask

    task t_standby;
        int rb[7] = '{8, 7, 4, 3, 2, 1, 0};
        @(posedge aclk);
        {main_clock_en, pullup_en, low_side_switch_1_en, low_side_switch_0_en, bias_en, excitation_en,
            reference_en} <= 7'h7f;
        standby <= 1;
        for (int i = 0; i < 7; i++) begin
            axi_write(stb_addr, (1 << rb[i]) | (rb[i] == 1), 4'b0011);
            repeat (2) @(negedge aclk);
            chk(outs, (1 << (6 - i)) | (rb[i] == 1));
        end
        axi_write(stb_addr, 32'h0000_019f, 4'b0011);
        {main_clock_en, pullup_en, low_side_switch_1_en, low_side_switch_0_en, bias_en, excitation_en,
            reference_en} <= 7'h00;
        repeat (2) @(negedge aclk);
        chk(outs, 0);
        axi_write(stb_addr, 32'h0000_0000, 4'b0011);
        standby <= 0;
        {main_clock_en, pullup_en, low_side_switch_1_en, low_side_switch_0_en, bias_en, excitation_en,
            reference_en} <= 7'h55;
        repeat (2) @(negedge aclk);
        chk(outs, 7'h55);
    endtask

    initial begin
        aresetn = 0;
        {osc_q, resets_q, fail_count, n_tests} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, standby} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, ext_clk_pin, int_osc_clk} = '0;
        {main_clock_en, pullup_en, low_side_switch_1_en, low_side_switch_0_en, bias_en, excitation_en,
            reference_en} = '0;
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        t_reset_vals;
        t_regs;
        t_sources;
        t_dividers;
        t_standby;
        complete_run;
    end
endmodule // csc_clock_standby_tb
